// [hdl/sci_defines.vh]
// Register map, field positions and timing constants of the start-up controller
`ifndef SCI_DEFINES_VH
`define SCI_DEFINES_VH
// ==================================================
// Register addresses
`define SCI_A_SPCFG   16'h0000
`define SCI_A_UPD     16'h0005
`define SCI_A_MPIN    16'h0100
`define SCI_A_WDLO    16'h0108
`define SCI_A_WDHI    16'h0109
`define SCI_A_MASK    16'h010A
`define SCI_A_STAB    16'h0207
`define SCI_A_REFPD   16'h0A01
`define SCI_A_CLR     16'h0A05
`define SCI_A_CLRI    16'h0A06
`define SCI_A_CAL0    16'h0A20
`define SCI_A_FR0     16'h0A22
`define SCI_A_CAL1    16'h0A40
`define SCI_A_FR1     16'h0A42
`define SCI_A_SCST    16'h0D01
`define SCI_A_MON     16'h0D08
`define SCI_MPIN_N    16'h0006
`define SCI_IRQ_N     16'h0009
// ==================================================
// Fields and values
`define SCI_UPD_VAL   8'h01
`define SCI_B_4WIRE   7
`define SCI_B_2WIRE   6
`define SCI_B_CLRALL  0
`define SCI_B_WDRST   7
`define SCI_B_CAL     1
`define SCI_B_SYNC    2
`define SCI_B_FREERUN 0
`define SCI_B_STABLE  1
`define SCI_B_LOCKED  0
`define SCI_B_PP      7
`define SCI_WD_BIT    3
`define SCI_MF_IN     3'h0
`define SCI_MF_IRQALL 3'h1
`define SCI_MF_IRQCOM 3'h2
`define SCI_MF_IRQL0  3'h3
`define SCI_MF_IRQL1  3'h4
`define SCI_MF_WDOG   3'h5
`define SCI_STAB_DEF  8'h32
// ==================================================
// Timing
`define SCI_POR_MS    20
`define SCI_CLK_KHZ   10000
`define SCI_WDP_NS    40
`define SCI_CLK_NS    100
`endif

// [hdl/sci_startup_ctrl.v]
// Power-up reset, strap capture, buffered registers, IRQ, watchdog, system_clock_multiplier stability
// Notes on behaviour
// RULE1: 20 ms internal reset after supplies good
// RULE2: Power-up reset independent of reset pin
// RULE3: All six pins inputs after reset
// RULE4: Low pins inputs in reset, latched at release
// RULE5: Two straps pick profile load or skip
// RULE6: Mode strap selects SPI/I2C; straps give address
// RULE7: Four-wire SPI gives fifth pin to data out
// RULE8: Sixth pin only in I2C or two-wire
// RULE9: Update strobe commits buffered writes
// RULE10: Host updates before polling stable flag
// RULE11: Host follows staged programming sequence
// RULE12: Host calibrates, then clears free-run
// RULE13: Soft sync bit applied on update
// RULE14: Masked events set monitor bits
// RULE15: Clear registers, clear-all bit
// RULE16: Three IRQ groups, per-pin or shared
// RULE17: Masks off, open-drain pin by default
// RULE18: Watchdog off by default, IRQ, restart bit
// RULE19: Watchdog expiry pulses assigned pin
// RULE20: Stable after lock held stability time
// RULE21: Host checks stable before status readback
// RULE22: Calibration on rising edge of bit
// RULE23: Strap pattern held until next reset
`timescale 1ns/1ps
`default_nettype none
`include "sci_defines.vh"
module sci_startup_ctrl #(
    parameter POR_CYCLES = `SCI_POR_MS * `SCI_CLK_KHZ,
    parameter MS_CYCLES  = `SCI_CLK_KHZ
) (
    input  wire        core_clk,
    input  wire        resetn,
    input  wire        ext_reset_n,
    input  wire        supply_ok_3v3,
    input  wire        supply_ok_core,
    input  wire        system_clock_multiplier_pll_locked,
    input  wire [5:0]  mpin_in,
    input  wire [71:0] irq_event,
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [15:0] reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        sdo_data,
    input  wire        sdo_oe,
    output reg  [7:0]  reg_rdata,
    output reg  [5:0]  mpin_out,
    output reg  [5:0]  mpin_oe,
    output reg         device_in_reset,
    output reg  [1:0]  eeprom_profile,
    output reg         i2c_mode,
    output reg  [1:0]  i2c_addr,
    output reg  [7:0]  ref_power_down,
    output reg  [1:0]  loop_freerun,
    output reg  [1:0]  apll_cal_start,
    output reg  [1:0]  apll_soft_sync,
    output reg         system_clock_multiplier_stable,
    output reg  [2:0]  irq_group
);
// ==================================================
// Helpers
localparam integer WDP_RAW = `SCI_WDP_NS / `SCI_CLK_NS;
localparam integer WDP_CYC = (WDP_RAW < 1) ? 1 : WDP_RAW;

function hit;
    input [15:0] a;
    input [15:0] base;
    input [15:0] n;
    begin
        hit = (a >= base) && (a < base + n);
    end
endfunction

// ==================================================
// Synchronisers: {lock, core ok, 3v3 ok, reset pin, pins}
reg  [9:0] s1_reg;
reg  [9:0] s2_reg;
always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
        s1_reg <= 10'h000;
        s2_reg <= 10'h000;
    end else begin
        s1_reg <= {system_clock_multiplier_pll_locked, supply_ok_core, supply_ok_3v3, ext_reset_n, mpin_in};
        s2_reg <= s1_reg;
    end
end
wire       pin_rst    = ~s2_reg[6];
wire       supply_ok  = s2_reg[7] & s2_reg[8];
wire       pll_locked = s2_reg[9];

// ==================================================
// Power-up reset, counted from supplies good alone
reg [31:0] por_cnt_reg;
reg        por_act_reg;
always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
        por_cnt_reg <= 32'h0;
        por_act_reg <= 1'b1;
    end else if (!supply_ok) begin
        por_cnt_reg <= 32'h0; // RULE2
        por_act_reg <= 1'b1;
    end else if (por_act_reg) begin
        if (por_cnt_reg == POR_CYCLES - 1)
            por_act_reg <= 1'b0; // RULE1
        else
            por_cnt_reg <= por_cnt_reg + 32'h1;
    end
end
wire any_rst = por_act_reg | pin_rst;

// ==================================================
// Strap capture on the release edge only
always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
        device_in_reset <= 1'b1;
        eeprom_profile  <= 2'h0;
        i2c_mode        <= 1'b0;
        i2c_addr        <= 2'h0;
    end else begin
        device_in_reset <= any_rst;
        if (device_in_reset && !any_rst) begin // RULE4 RULE23
            eeprom_profile <= s2_reg[1:0]; // RULE5
            i2c_mode       <= s2_reg[3]; // RULE6
            i2c_addr       <= s2_reg[5:4]; // RULE6
        end
    end
end

// ==================================================
// Register file: shadow copies, committed by update, except spcfg_reg and refpd_sh_reg, which act at once
reg  [7:0]  spcfg_reg;
reg  [47:0] mpin_sh_reg;
reg  [47:0] mpin_act_reg;
reg  [15:0] wd_sh_reg;
reg  [15:0] wd_act_reg;
reg  [71:0] mask_sh_reg;
reg  [71:0] mask_act_reg;
reg  [7:0]  stab_sh_reg;
reg  [7:0]  stab_act_reg;
reg  [7:0]  refpd_sh_reg;
reg  [31:0] loop_sh_reg;
reg  [31:0] loop_act_reg;
reg  [71:0] mon_reg;
reg  [71:0] clr_next;
reg         wd_restart;
wire [15:0] d_mpin = reg_addr - `SCI_A_MPIN;
wire [15:0] d_mask = reg_addr - `SCI_A_MASK;
wire [15:0] d_clri = reg_addr - `SCI_A_CLRI;
wire [15:0] d_mon  = reg_addr - `SCI_A_MON;
wire        upd    = reg_wr && reg_addr == `SCI_A_UPD && reg_wdata == `SCI_UPD_VAL;
wire        wd_exp;
wire [71:0] ev_vec = irq_event | ({71'h0, wd_exp} << `SCI_WD_BIT);

always @* begin
    clr_next   = 72'h0;
    wd_restart = 1'b0;
    if (reg_wr && reg_addr == `SCI_A_CLR) begin
        if (reg_wdata[`SCI_B_CLRALL])
            clr_next = {72{1'b1}}; // RULE15
        wd_restart = reg_wdata[`SCI_B_WDRST]; // RULE18
    end else if (reg_wr && hit(reg_addr, `SCI_A_CLRI, `SCI_IRQ_N)) begin
        clr_next[8*d_clri[3:0] +: 8] = reg_wdata; // RULE15
    end
end

always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
        spcfg_reg    <= 8'h00;
        mpin_sh_reg  <= 48'h0;
        mpin_act_reg <= 48'h0;
        wd_sh_reg    <= 16'h0;
        wd_act_reg   <= 16'h0;
        mask_sh_reg  <= 72'h0;
        mask_act_reg <= 72'h0;
        stab_sh_reg  <= `SCI_STAB_DEF;
        stab_act_reg <= `SCI_STAB_DEF;
        refpd_sh_reg <= 8'h00;
        loop_sh_reg  <= 32'h0;
        loop_act_reg <= 32'h0;
        mon_reg      <= 72'h0;
    end else if (any_rst) begin
        spcfg_reg    <= 8'h00;
        mpin_sh_reg  <= 48'h0; // RULE3
        mpin_act_reg <= 48'h0; // RULE3
        wd_sh_reg    <= 16'h0; // RULE18
        wd_act_reg   <= 16'h0;
        mask_sh_reg  <= 72'h0; // RULE17
        mask_act_reg <= 72'h0;
        stab_sh_reg  <= `SCI_STAB_DEF;
        stab_act_reg <= `SCI_STAB_DEF;
        refpd_sh_reg <= 8'h00;
        loop_sh_reg  <= 32'h0;
        loop_act_reg <= 32'h0;
        mon_reg      <= 72'h0;
    end else begin
        // Set wins over a clear arriving in the same cycle
        mon_reg <= (mon_reg & ~clr_next) | (ev_vec & mask_act_reg); // RULE14
        if (reg_wr) begin
            if (reg_addr == `SCI_A_SPCFG)
                spcfg_reg <= reg_wdata;
            if (hit(reg_addr, `SCI_A_MPIN, `SCI_MPIN_N))
                mpin_sh_reg[8*d_mpin[2:0] +: 8] <= reg_wdata;
            if (reg_addr == `SCI_A_WDLO)
                wd_sh_reg[7:0] <= reg_wdata;
            if (reg_addr == `SCI_A_WDHI)
                wd_sh_reg[15:8] <= reg_wdata;
            if (hit(reg_addr, `SCI_A_MASK, `SCI_IRQ_N))
                mask_sh_reg[8*d_mask[3:0] +: 8] <= reg_wdata;
            if (reg_addr == `SCI_A_STAB)
                stab_sh_reg <= reg_wdata;
            if (reg_addr == `SCI_A_REFPD)
                refpd_sh_reg <= reg_wdata;
            if (reg_addr == `SCI_A_CAL0)
                loop_sh_reg[7:0] <= reg_wdata;
            if (reg_addr == `SCI_A_FR0)
                loop_sh_reg[15:8] <= reg_wdata;
            if (reg_addr == `SCI_A_CAL1)
                loop_sh_reg[23:16] <= reg_wdata;
            if (reg_addr == `SCI_A_FR1)
                loop_sh_reg[31:24] <= reg_wdata;
        end
        if (upd) begin // RULE9
            mpin_act_reg <= mpin_sh_reg;
            wd_act_reg   <= wd_sh_reg;
            mask_act_reg <= mask_sh_reg;
            stab_act_reg <= stab_sh_reg;
            loop_act_reg <= loop_sh_reg;
        end
    end
end

// ==================================================
// Millisecond tick shared by watchdog and stability timer
reg [31:0] ms_cnt_reg;
wire       ms_tick = (ms_cnt_reg == MS_CYCLES - 1);
always @(posedge core_clk or negedge resetn) begin
    if (!resetn)
        ms_cnt_reg <= 32'h0;
    else if (any_rst || ms_tick)
        ms_cnt_reg <= 32'h0;
    else
        ms_cnt_reg <= ms_cnt_reg + 32'h1;
end

// ==================================================
// Watchdog: period zero means disabled
reg [15:0] wd_ms_reg;
reg [7:0]  wdp_cnt_reg;
wire       wd_on = (wd_act_reg != 16'h0);
assign wd_exp = wd_on && ms_tick && (wd_ms_reg == wd_act_reg - 16'h1); // RULE18
always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
        wd_ms_reg   <= 16'h0;
        wdp_cnt_reg <= 8'h00;
    end else begin
        if (any_rst || !wd_on || wd_restart || wd_exp)
            wd_ms_reg <= 16'h0; // RULE18
        else if (ms_tick)
            wd_ms_reg <= wd_ms_reg + 16'h1;
        if (any_rst)
            wdp_cnt_reg <= 8'h00;
        else if (wd_exp)
            wdp_cnt_reg <= WDP_CYC[7:0]; // RULE19
        else if (wdp_cnt_reg != 8'h00)
            wdp_cnt_reg <= wdp_cnt_reg - 8'h01;
    end
end

// ==================================================
// System clock stability timer
reg [7:0] st_ms_reg;
always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
        st_ms_reg     <= 8'h00;
        system_clock_multiplier_stable <= 1'b0;
    end else if (any_rst || !pll_locked) begin
        st_ms_reg     <= 8'h00;
        system_clock_multiplier_stable <= 1'b0;
    end else if (!system_clock_multiplier_stable) begin
        if (st_ms_reg >= stab_act_reg)
            system_clock_multiplier_stable <= 1'b1; // RULE20
        else if (ms_tick)
            st_ms_reg <= st_ms_reg + 8'h01;
    end
end

// ==================================================
// Loop controls: calibration on rising edge only
reg [1:0] cal_q_reg;
wire [1:0] cal_lvl = {loop_act_reg[16 + `SCI_B_CAL], loop_act_reg[`SCI_B_CAL]};
always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
        cal_q_reg      <= 2'h0;
        apll_cal_start <= 2'h0;
        apll_soft_sync <= 2'h0;
        loop_freerun   <= 2'h0;
        ref_power_down <= 8'h00;
        irq_group      <= 3'h0;
    end else begin
        cal_q_reg      <= cal_lvl;
        apll_cal_start <= cal_lvl & ~cal_q_reg; // RULE22
        apll_soft_sync <= {loop_act_reg[16 + `SCI_B_SYNC], loop_act_reg[`SCI_B_SYNC]}; // RULE13
        loop_freerun   <= {loop_act_reg[24 + `SCI_B_FREERUN], loop_act_reg[8 + `SCI_B_FREERUN]};
        ref_power_down <= refpd_sh_reg;
        irq_group      <= {|mon_reg[71:48], |mon_reg[47:24], |mon_reg[23:0]}; // RULE16
    end
end

// ==================================================
// Multifunction pin drive
reg [5:0]  mo_next;
reg [5:0]  moe_next;
reg        lvl;
reg [2:0]  fn;
reg        avail;
integer    i;
wire       spi4 = !i2c_mode && spcfg_reg[`SCI_B_4WIRE];
always @* begin
    mo_next  = 6'h00;
    moe_next = 6'h00;
    lvl      = 1'b0;
    fn       = `SCI_MF_IN;
    avail    = 1'b0;
    for (i = 0; i < 6; i = i + 1) begin
        fn    = mpin_act_reg[8*i +: 3];
        avail = (i < 4) || (i == 4 && !spi4)
                || (i == 5 && (i2c_mode || spcfg_reg[`SCI_B_2WIRE])); // RULE7 RULE8
        case (fn)
            `SCI_MF_IRQALL: lvl = |irq_group;
            `SCI_MF_IRQCOM: lvl = irq_group[0];
            `SCI_MF_IRQL0:  lvl = irq_group[1];
            `SCI_MF_IRQL1:  lvl = irq_group[2];
            `SCI_MF_WDOG:   lvl = (wdp_cnt_reg != 8'h00); // RULE19
            default:        lvl = 1'b0;
        endcase
        if (!avail || fn == `SCI_MF_IN) begin
            mo_next[i]  = 1'b0;
            moe_next[i] = 1'b0;
        end else if (fn == `SCI_MF_WDOG || mpin_act_reg[8*i + `SCI_B_PP]) begin
            mo_next[i]  = lvl;
            moe_next[i] = 1'b1;
        end else begin
            // Open drain: pull low while active
            mo_next[i]  = 1'b0;
            moe_next[i] = lvl; // RULE17
        end
    end
    if (spi4) begin
        mo_next[4]  = sdo_data; // RULE7
        moe_next[4] = sdo_oe;
    end
    if (any_rst) begin
        moe_next = 6'h00; // RULE3 RULE4
    end
end

always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
        mpin_out <= 6'h00;
        mpin_oe  <= 6'h00;
    end else begin
        mpin_out <= mo_next;
        mpin_oe  <= moe_next;
    end
end

// ==================================================
// Read-back of shadow values and status
reg [7:0] rd_next;
always @* begin
    rd_next = 8'h00;
    if (reg_addr == `SCI_A_SPCFG)
        rd_next = spcfg_reg;
    else if (hit(reg_addr, `SCI_A_MPIN, `SCI_MPIN_N))
        rd_next = mpin_sh_reg[8*d_mpin[2:0] +: 8];
    else if (reg_addr == `SCI_A_WDLO)
        rd_next = wd_sh_reg[7:0];
    else if (reg_addr == `SCI_A_WDHI)
        rd_next = wd_sh_reg[15:8];
    else if (hit(reg_addr, `SCI_A_MASK, `SCI_IRQ_N))
        rd_next = mask_sh_reg[8*d_mask[3:0] +: 8];
    else if (reg_addr == `SCI_A_STAB)
        rd_next = stab_sh_reg;
    else if (reg_addr == `SCI_A_REFPD)
        rd_next = refpd_sh_reg;
    else if (reg_addr == `SCI_A_CAL0)
        rd_next = loop_sh_reg[7:0];
    else if (reg_addr == `SCI_A_FR0)
        rd_next = loop_sh_reg[15:8];
    else if (reg_addr == `SCI_A_CAL1)
        rd_next = loop_sh_reg[23:16];
    else if (reg_addr == `SCI_A_FR1)
        rd_next = loop_sh_reg[31:24];
    else if (reg_addr == `SCI_A_SCST) begin
        rd_next[`SCI_B_STABLE] = system_clock_multiplier_stable;
        rd_next[`SCI_B_LOCKED] = pll_locked;
    end else if (hit(reg_addr, `SCI_A_MON, `SCI_IRQ_N))
        rd_next = mon_reg[8*d_mon[3:0] +: 8];
end

always @(posedge core_clk or negedge resetn) begin
    if (!resetn)
        reg_rdata <= 8'h00;
    else if (reg_rd)
        reg_rdata <= rd_next;
end
endmodule // sci_startup_ctrl
`default_nettype wire

// [testbench/sci_host_model.sv]
// Host model behind the serial port: register writes, reads, updates
`timescale 1ns/1ps
`default_nettype none
module sci_host_model (
    input  wire logic        core_clk,
    input  wire logic [7:0]  reg_rdata,
    output var  logic        reg_wr,
    output var  logic        reg_rd,
    output var  logic [15:0] reg_addr,
    output var  logic [7:0]  reg_wdata
);
    initial begin
        reg_wr = 1'h0;
        reg_rd = 1'h0;
        reg_addr = 16'hFFFF;
        reg_wdata = 8'hFF;
    end
    // ==================================================
    // Bus cycles; released lines show inverted values
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'h0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        reg_addr <= ~a;
        @(posedge core_clk);
        #1 d = reg_rdata;
    endtask
    task automatic upd();
        wr(16'h0005, 8'h01);
    endtask
    // Status is only trusted right after a fresh update
    task automatic stat(output logic [7:0] d);
        upd();
        rd(16'h0D01, d);
    endtask
endmodule // sci_host_model
`default_nettype wire

// [testbench/sci_startup_checker.sv]
// Port-level assertions for the start-up controller
`timescale 1ns/1ps
`default_nettype none
module sci_startup_checker #(
    parameter POR_CYCLES = 200000
) (
    input wire logic       core_clk,
    input wire logic       resetn,
    input wire logic       ext_reset_n,
    input wire logic       supply_ok_3v3,
    input wire logic       supply_ok_core,
    input wire logic       system_clock_multiplier_pll_locked,
    input wire logic [5:0] mpin_oe,
    input wire logic       device_in_reset,
    input wire logic [1:0] eeprom_profile,
    input wire logic       i2c_mode,
    input wire logic [1:0] i2c_addr,
    input wire logic [1:0] apll_cal_start,
    input wire logic       system_clock_multiplier_stable
);
    wire sup_ok = supply_ok_3v3 & supply_ok_core;
    // Run of good-supply cycles; logic reset restarts it so a short reset cannot hide
    logic [31:0] ok_run;
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn)
            ok_run <= 32'h0;
        else if (!sup_ok)
            ok_run <= 32'h0;
        else if (ok_run != 32'hFFFFFFFF)
            ok_run <= ok_run + 32'h1;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // ==================================================
    // Reset and straps
    property p_por_len; $fell(device_in_reset) |-> ok_run >= POR_CYCLES; endproperty
    a_por_len: assert property (p_por_len) else $error("reset ended too early");
    property p_sup_drop; !sup_ok |-> ##[1:4] device_in_reset; endproperty
    a_sup_drop: assert property (p_sup_drop) else $error("no reset on supply loss");
    property p_pin_rst; !ext_reset_n |-> ##[1:4] device_in_reset; endproperty
    a_pin_rst: assert property (p_pin_rst) else $error("no reset from pin");
    property p_pins_in; device_in_reset && $past(device_in_reset) |-> mpin_oe == 6'h00; endproperty
    a_pins_in: assert property (p_pins_in) else $error("pin driven in reset");
    // Straps must not drift between capture and the next reset
    property p_strap_hold;
        !device_in_reset && !$past(device_in_reset)
            |-> $stable(eeprom_profile) && $stable(i2c_mode) && $stable(i2c_addr);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap changed");
    // ==================================================
    // Calibration and system clock
    property p_cal_pulse; apll_cal_start != 2'h0 |=> apll_cal_start == 2'h0; endproperty
    a_cal_pulse: assert property (p_cal_pulse) else $error("cal start too long");
    property p_lock_loss; $fell(system_clock_multiplier_pll_locked) |-> ##[1:4] !system_clock_multiplier_stable; endproperty
    a_lock_loss: assert property (p_lock_loss) else $error("stable kept");
    property p_stab_lock; $rose(system_clock_multiplier_stable) |-> $past(system_clock_multiplier_pll_locked, 3); endproperty
    a_stab_lock: assert property (p_stab_lock) else $error("stable without lock");
endmodule // sci_startup_checker

bind sci_startup_ctrl sci_startup_checker #(.POR_CYCLES(POR_CYCLES)) u_chk (
    .core_clk, .resetn, .ext_reset_n, .supply_ok_3v3, .supply_ok_core, .system_clock_multiplier_pll_locked,
    .mpin_oe, .device_in_reset, .eeprom_profile, .i2c_mode, .i2c_addr, .apll_cal_start,
    .system_clock_multiplier_stable);
`default_nettype wire

// [testbench/sci_startup_ctrl_test.sv]
// Self-checking bench for the start-up, IRQ and watchdog controller
`timescale 1ns/1ps
`default_nettype none
module sci_startup_ctrl_test;
    localparam int POR = 20;
    localparam int MS  = 10;
    logic        core_clk, resetn, ext_reset_n, supply_ok_3v3, supply_ok_core;
    logic        system_clock_multiplier_pll_locked, sdo_data, sdo_oe, reg_wr, reg_rd;
    logic        device_in_reset, i2c_mode, system_clock_multiplier_stable;
    logic [5:0]  mpin_in, mpin_out, mpin_oe;
    logic [71:0] irq_event;
    logic [15:0] reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, ref_power_down, rd_val;
    logic [1:0]  eeprom_profile, i2c_addr, loop_freerun, apll_cal_start, apll_soft_sync;
    logic [2:0]  irq_group;
    logic [31:0] rows [8];
    int          n_errors = 0, check_count = 0, n_cal = 0, n_wd = 0, cnt;

    sci_startup_ctrl #(.POR_CYCLES(POR), .MS_CYCLES(MS)) DUT (
        .core_clk, .resetn, .ext_reset_n, .supply_ok_3v3, .supply_ok_core,
        .system_clock_multiplier_pll_locked, .mpin_in, .irq_event, .reg_wr, .reg_rd, .reg_addr,
        .reg_wdata, .sdo_data, .sdo_oe, .reg_rdata, .mpin_out, .mpin_oe,
        .device_in_reset, .eeprom_profile, .i2c_mode, .i2c_addr, .ref_power_down,
        .loop_freerun, .apll_cal_start, .apll_soft_sync, .system_clock_multiplier_stable, .irq_group);
    sci_host_model HOST (.core_clk, .reg_rdata, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);

    initial core_clk = 1'h0;
    always #50 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        n_cal <= n_cal + int'(apll_cal_start[0]);
        n_wd <= n_wd + int'(mpin_out[1]);
    end
    // ==================================================
    // Helpers
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic pulse(input int b);
        @(posedge core_clk);
        irq_event[b] <= 1'h1;
        @(posedge core_clk);
        irq_event[b] <= 1'h0;
        step(5);
    endtask
    task automatic wait_rel(output int c);
        c = 0;
        while (device_in_reset !== 1'h0 && c < 80) begin
            @(posedge core_clk);
            #1 c++;
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #400000;
        n_errors++;
        tally_and_finish();
    end
    // ==================================================
    // Tests
    initial begin
        rows = '{32'h00004040, 32'h0A015A5A, 32'h00050100, 32'h0D01FF00,
                 32'h0FFE7700, 32'h0A058000, 32'h02070303, 32'h010A0909};
        resetn = 1'h0;
        ext_reset_n = 1'h1;
        supply_ok_3v3 = 1'h1;
        supply_ok_core = 1'h1;
        system_clock_multiplier_pll_locked = 1'h0;
        sdo_data = 1'h0;
        sdo_oe = 1'h0;
        mpin_in = 6'h22;
        irq_event = 72'h0;
        repeat (12) @(posedge core_clk);
        resetn <= 1'h1;
        step(5);
        chk("in_reset", 8'h01, 8'(device_in_reset));
        wait_rel(cnt);
        chk("por_len", 8'h01, 8'(cnt + 5 >= POR));
        @(posedge core_clk) mpin_in <= 6'h1D;
        step(8);
        chk("straps", 8'h12, {3'h0, eeprom_profile, i2c_mode, i2c_addr});
        chk("pin_oe", 8'h00, 8'(mpin_oe));
        $display("test strap done");
        pulse(0);
        chk("irq_off", 8'h00, 8'(irq_group));
        HOST.wr(16'h0000, 8'h80);
        sdo_oe <= 1'h1;
        sdo_data <= 1'h1;
        step(3);
        chk("sdo_pin", 8'h03, {6'h00, mpin_oe[4], mpin_out[4]});
        foreach (rows[i]) begin
            HOST.wr(rows[i][31:16], rows[i][15:8]);
            HOST.rd(rows[i][31:16], rd_val);
            chk("reg_rd", rows[i][7:0], rd_val);
        end
        chk("ref_pd", 8'h5A, ref_power_down);
        chk("pin4_free", 8'h00, 8'(mpin_oe[4]));
        HOST.upd();
        pulse(0);
        chk("irq_grp", 8'h01, 8'(irq_group));
        HOST.rd(16'h0D08, rd_val);
        chk("irq_mon", 8'h01, rd_val);
        HOST.wr(16'h0A06, 8'h01);
        HOST.rd(16'h0D08, rd_val);
        chk("irq_clr", 8'h00, rd_val);
        HOST.wr(16'h0100, 8'h01);
        HOST.wr(16'h0110, 8'h01);
        HOST.wr(16'h0105, 8'h84);
        HOST.upd();
        pulse(48);
        chk("irq_l1", 8'h04, 8'(irq_group));
        chk("irq_pin", 8'h02, {6'h00, mpin_oe[0], mpin_out[0]});
        chk("pin5_l1", 8'h03, {6'h00, mpin_oe[5], mpin_out[5]});
        HOST.wr(16'h0A05, 8'h01);
        step(3);
        chk("irq_all", 8'h00, {4'h0, irq_group, mpin_oe[0]});
        HOST.wr(16'h0000, 8'h00);
        step(3);
        chk("pin5_off", 8'h00, 8'(mpin_oe[5]));
        $display("test irq done");
        HOST.wr(16'h0A22, 8'h01);
        HOST.wr(16'h0005, 8'h02);
        step(3);
        chk("fr_hold", 8'h00, 8'(loop_freerun));
        HOST.upd();
        step(3);
        chk("fr_set", 8'h01, 8'(loop_freerun));
        cnt = n_cal;
        HOST.wr(16'h0A20, 8'h02);
        HOST.upd();
        HOST.upd();
        step(3);
        chk("cal_once", 8'h01, 8'(n_cal - cnt));
        HOST.wr(16'h0A20, 8'h00);
        HOST.upd();
        HOST.wr(16'h0A20, 8'h02);
        HOST.upd();
        HOST.wr(16'h0A40, 8'h04);
        HOST.upd();
        step(3);
        chk("cal_again", 8'h02, 8'(n_cal - cnt));
        chk("sync", 8'h02, 8'(apll_soft_sync));
        $display("test update done");
        HOST.wr(16'h0108, 8'h02);
        HOST.wr(16'h0101, 8'h85);
        step(1);
        cnt = n_wd;
        HOST.upd();
        step(50);
        chk("wd_pulses", 8'h02, 8'(n_wd - cnt));
        chk("wd_irq", 8'h01, 8'(irq_group[0]));
        HOST.wr(16'h0A05, 8'h80);
        step(2);
        cnt = n_wd;
        repeat (8) begin
            step(3);
            HOST.wr(16'h0A05, 8'h80);
        end
        step(1);
        chk("wd_restart", 8'h00, 8'(n_wd - cnt));
        $display("test watchdog done");
        @(posedge core_clk) system_clock_multiplier_pll_locked <= 1'h1;
        step(15);
        chk("stab_early", 8'h00, 8'(system_clock_multiplier_stable));
        step(30);
        HOST.stat(rd_val);
        chk("stab_reg", 8'h03, rd_val);
        @(posedge core_clk) system_clock_multiplier_pll_locked <= 1'h0;
        step(5);
        chk("stab_loss", 8'h00, 8'(system_clock_multiplier_stable));
        $display("test system_clock_multiplier done");
        @(posedge core_clk) ext_reset_n <= 1'h0;
        step(5);
        chk("ext_rst", 8'h01, 8'(device_in_reset));
        @(posedge core_clk) ext_reset_n <= 1'h1;
        wait_rel(cnt);
        chk("restrap", 8'h0D, {3'h0, eeprom_profile, i2c_mode, i2c_addr});
        HOST.rd(16'h010A, rd_val);
        chk("mask_def", 8'h00, rd_val);
        @(posedge core_clk) supply_ok_core <= 1'h0;
        step(5);
        chk("sup_rst", 8'h01, 8'(device_in_reset));
        @(posedge core_clk) supply_ok_core <= 1'h1;
        wait_rel(cnt);
        chk("por_len2", 8'h01, 8'(cnt >= POR));
        $display("test reset done");
        tally_and_finish();
    end
endmodule // sci_startup_ctrl_test
`default_nettype wire
